// ### rtl/lcdcc_params.svh
`ifndef LCDCC_PARAMS_SVH
`define LCDCC_PARAMS_SVH
// ----------------------------------------
// command decode fields, panel size and frame divisors
// ----------------------------------------
`define LCDCC_PAGE_ICON 3'h4
`define LCDCC_NUM_PAGES 5
`define LCDCC_NUM_COLS 120
`define LCDCC_COL_LAST 7'h77
`define LCDCC_RD_CONTRAST_HI 4'h1
`define LCDCC_DIV_SLOW 576
`define LCDCC_DIV_NORMAL 768
`define LCDCC_ROW_LAST 5'h1f
// ----------------------------------------
// reset values
// ----------------------------------------
`define LCDCC_RST_PAGE 3'h0
`define LCDCC_RST_COL 7'h00
`define LCDCC_RST_CONTRAST 4'h0
`define LCDCC_RST_ICON_CONTRAST 2'h2
`endif

// ### rtl/lcdcc_pkg.sv
package lcdcc_pkg;
	typedef enum logic [1:0] {
		LCDCC_CLR_NONE = 2'h0,
		LCDCC_CLR_RAM = 2'h1,
		LCDCC_CLR_ICON = 2'h2
	} lcdcc_clear_t;
	typedef enum logic [2:0] {
		LCDCC_MUX32 = 3'h1,
		LCDCC_MUX33 = 3'h2,
		LCDCC_MUX16 = 3'h4
	} lcdcc_mux_t;
endpackage : lcdcc_pkg

// ### rtl/lcdcc_frame_div.sv
`timescale 1ns/1ps
`include "lcdcc_params.svh"
module lcdcc_frame_div #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic osc_tick,
	input wire logic run,
	input wire logic clk_normal,
	output logic frame_tick
);
	logic [W-1:0] cnt;
	logic [W-1:0] last;
	// ----------------------------------------
	// frame divider
	// ----------------------------------------
	assign last = clk_normal ? W'(`LCDCC_DIV_NORMAL - 1) :
		W'(`LCDCC_DIV_SLOW - 1);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			frame_tick <= 1'b0;
		end else begin
			frame_tick <= 1'b0;
			if (!run) begin
				cnt <= '0;
			end else if (osc_tick) begin
				if (cnt >= last) begin
					cnt <= '0;
					frame_tick <= 1'b1;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
	end
endmodule : lcdcc_frame_div

// ### rtl/lcdcc_core.sv
// Functional notes
// - display on drives commons, segments and bias; static icons unchanged
// - display off: outputs at lowest bias, bias off, state kept
// - display off leaves static icons and oscillator enable alone
// - page command selects one of five page rows
// - clear ram zeroes pages 1-4 on the following dummy write
// - clear icons zeroes page 5 after following dummy write, only if page 5 is selected
// - icon line command sets or clears 1/33 mux unless 16 mux is on, and always leaves icon-only mode
// - icon mode drives only the icon line
// - common k shows row (scroll+k) mod 32; common 32 fixed
// - option 1 saves column pointer, option 0 restores it
// - one bit reverses column to segment order
// - one bit reverses row to common order
// - static icon command sets each of four icons alone
// - oscillator enable changes only by its own command
// - frame rate is oscillator over 576 slow, 768 normal
// - doubler/tripler choice acts only with converter on
// - regulator bit enables regulator and temp compensation
// - divider on picks bias from bias bit, 1/5 forced in 16 mux; off means external bias
// - 16 mux: unused commons dummy scan, doubler forced
// - contrast step moves 16-level value by one only with contrast control on; resets lowest
// - command read with high nibble 0001 returns contrast
// - data write stores byte and advances column pointer
// - dummy write after clear does not advance column
// - column pointer wraps on overflow
// - contrast step wraps within 16 levels
`timescale 1ns/1ps
`include "lcdcc_params.svh"
module lcdcc_core #(
	parameter int COLS = `LCDCC_NUM_COLS,
	parameter int PAGES = `LCDCC_NUM_PAGES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe,
	input wire logic data_command_select,
	input wire logic rw,
	input wire logic [7:0] d_in,
	output logic [7:0] d_out,
	output logic d_oe,
	input wire logic osc_tick,
	input wire logic [2:0] scan_page,
	input wire logic [6:0] scan_col,
	input wire logic [4:0] scan_com,
	output logic [7:0] scan_byte,
	output logic [4:0] scan_row,
	output logic [6:0] scan_seg_col,
	output logic display_on,
	output logic drivers_active,
	output logic bias_on,
	output logic [3:0] static_icon,
	output logic [1:0] icon_contrast,
	output logic osc_enable,
	output logic osc_external,
	output logic clk_normal,
	output logic dcdc_on,
	output logic doubler_sel,
	output logic regulator_on,
	output logic contrast_ctrl_on,
	output logic temp_comp_on,
	output logic [1:0] temp_coef,
	output logic divider_on,
	output logic bias_fifth,
	output logic [3:0] contrast,
	output logic [2:0] mux_sel,
	output logic icon_only,
	output logic dummy_scan,
	output logic idd_reduce,
	output logic [2:0] page,
	output logic [6:0] column,
	output logic frame_tick
);
	// ----------------------------------------
	// strobe decode
	// ----------------------------------------
	logic strobe_q;
	logic take;
	logic cmd_wr;
	logic data_wr;
	logic data_rd;
	logic cmd_rd;
	logic [7:0] ram [PAGES*COLS];
	logic [6:0] col_save;
	logic col_rev;
	logic row_rev;
	logic [4:0] scroll;
	logic duty16;
	logic icon_line;
	logic bias5;
	logic doubler_q;
	lcdcc_pkg::lcdcc_clear_t clr_pend;
	logic [6:0] next_column;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= strobe;
		end
	end
	// falling edge only: the latch edge of the parallel port
	assign take = strobe_q & ~strobe;
	assign cmd_wr = take & ~data_command_select & ~rw;
	assign cmd_rd = take & ~data_command_select & rw;
	assign data_wr = take & data_command_select & ~rw;
	assign data_rd = take & data_command_select & rw;
	// ----------------------------------------
	// column pointer
	// ----------------------------------------
	always_comb begin
		if (column >= `LCDCC_COL_LAST) begin
			next_column = `LCDCC_RST_COL;
		end else begin
			next_column = column + 7'h01;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			column <= `LCDCC_RST_COL;
			col_save <= `LCDCC_RST_COL;
		end else if (cmd_wr && d_in[7]) begin
			column <= d_in[6:0];
		end else if (cmd_wr && d_in[7:1] == 7'h1a) begin
			if (d_in[0]) begin
				col_save <= column;
			end else begin
				column <= col_save;
			end
		end else if ((data_wr && clr_pend == lcdcc_pkg::LCDCC_CLR_NONE)
			|| data_rd) begin
			column <= next_column;
		end
	end
	// ----------------------------------------
	// display ram
	// ----------------------------------------
	// clear is done in one cycle: flops make this cheap to write,
	// costly in area
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_pend <= lcdcc_pkg::LCDCC_CLR_NONE;
		end else if (cmd_wr && d_in == 8'h36) begin
			clr_pend <= lcdcc_pkg::LCDCC_CLR_RAM;
		end else if (cmd_wr && d_in == 8'h37) begin
			clr_pend <= lcdcc_pkg::LCDCC_CLR_ICON;
		end else if (data_wr) begin
			clr_pend <= lcdcc_pkg::LCDCC_CLR_NONE;
		end
	end
	for (genvar i = 0; i < PAGES * COLS; i++) begin : g_ram
		localparam logic [2:0] PG = 3'(i / COLS);
		localparam logic [6:0] CL = 7'(i % COLS);
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				ram[i] <= 8'h00;
			end else if (data_wr) begin
				if (clr_pend == lcdcc_pkg::LCDCC_CLR_RAM) begin
					if (PG != `LCDCC_PAGE_ICON) begin
						ram[i] <= 8'h00;
					end
				end else if (clr_pend == lcdcc_pkg::LCDCC_CLR_ICON) begin
					if (PG == `LCDCC_PAGE_ICON
						&& page == `LCDCC_PAGE_ICON) begin
						ram[i] <= 8'h00;
					end
				end else if (PG == page && CL == column) begin
					ram[i] <= d_in;
				end
			end
		end
	end
	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d_out <= 8'h00;
			d_oe <= 1'b0;
		end else if (cmd_rd) begin
			d_oe <= 1'b1;
			if (d_in[7:4] == `LCDCC_RD_CONTRAST_HI) begin
				d_out <= {4'h0, contrast};
			end else begin
				d_out <= 8'h00;
			end
		end else if (data_rd) begin
			d_oe <= 1'b1;
			// columns past the panel width hold no byte
			if (int'(column) < COLS) begin
				d_out <= ram[int'(page) * COLS + int'(column)];
			end else begin
				d_out <= 8'h00;
			end
		end else if (strobe) begin
			d_oe <= 1'b0;
		end
	end
	// ----------------------------------------
	// command registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page <= `LCDCC_RST_PAGE;
		end else if (cmd_wr && d_in[7:3] == 5'h00
			&& d_in[2:0] <= `LCDCC_PAGE_ICON) begin
			page <= d_in[2:0];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			contrast <= `LCDCC_RST_CONTRAST;
			icon_contrast <= `LCDCC_RST_ICON_CONTRAST;
		end else if (cmd_wr && d_in[7:4] == 4'h1) begin
			contrast <= d_in[3:0];
		end else if (cmd_wr && d_in[7:2] == 6'h03) begin
			icon_contrast <= d_in[1:0];
		end else if (cmd_wr && d_in[7:1] == 7'h38 && contrast_ctrl_on) begin
			// 4-bit arithmetic wraps by itself
			contrast <= d_in[0] ? contrast + 4'h1 :
				contrast - 4'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			doubler_q <= 1'b0;
			col_rev <= 1'b0;
			row_rev <= 1'b0;
			display_on <= 1'b0;
			dcdc_on <= 1'b0;
			regulator_on <= 1'b0;
			divider_on <= 1'b0;
			contrast_ctrl_on <= 1'b0;
			clk_normal <= 1'b0;
			bias5 <= 1'b0;
			idd_reduce <= 1'b0;
			osc_external <= 1'b0;
			osc_enable <= 1'b0;
			duty16 <= 1'b0;
		end else if (cmd_wr && d_in[7:4] == 4'h2) begin
			unique case (d_in[3:1])
				3'h0: doubler_q <= d_in[0];
				3'h1: col_rev <= d_in[0];
				3'h2: row_rev <= d_in[0];
				3'h4: display_on <= d_in[0];
				3'h5: dcdc_on <= d_in[0];
				3'h6: regulator_on <= d_in[0];
				3'h7: divider_on <= d_in[0];
				default: ;
			endcase
		end else if (cmd_wr && d_in[7:4] == 4'h3) begin
			unique case (d_in[3:1])
				3'h0: contrast_ctrl_on <= d_in[0];
				3'h1: clk_normal <= d_in[0];
				3'h4: bias5 <= d_in[0];
				default: ;
			endcase
		end else if (cmd_wr && d_in[7:1] == 7'h34) begin
			duty16 <= d_in[0];
		end else if (cmd_wr && d_in[7:1] == 7'h35) begin
			idd_reduce <= d_in[0];
		end else if (cmd_wr && d_in[7:1] == 7'h3d) begin
			osc_external <= d_in[0];
		end else if (cmd_wr && d_in[7:1] == 7'h3f) begin
			osc_enable <= d_in[0];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_coef <= 2'h0;
			scroll <= 5'h00;
		end else if (cmd_wr && d_in[7:2] == 6'h1b) begin
			temp_coef <= d_in[1:0];
		end else if (cmd_wr && d_in[7:5] == 3'h2) begin
			scroll <= d_in[4:0];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			static_icon <= 4'h0;
		end else if (cmd_wr && d_in[7:3] == 5'h0c) begin
			static_icon[d_in[2:1]] <= d_in[0];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			icon_line <= 1'b0;
			icon_only <= 1'b0;
		end else if (cmd_wr && d_in[7:1] == 7'h1e) begin
			icon_line <= d_in[0];
			icon_only <= 1'b0;
		end else if (cmd_wr && d_in == 8'h3e) begin
			icon_only <= 1'b1;
		end
	end
	// ----------------------------------------
	// derived display controls
	// ----------------------------------------
	assign drivers_active = display_on;
	assign bias_on = display_on;
	assign temp_comp_on = regulator_on;
	assign dummy_scan = duty16 & display_on;
	// converter off leaves the choice latched but without effect
	always_comb begin
		if (!dcdc_on) begin
			doubler_sel = 1'b0;
		end else begin
			doubler_sel = duty16 | doubler_q;
		end
	end
	always_comb begin
		if (icon_only) begin
			mux_sel = 3'(lcdcc_pkg::LCDCC_MUX33);
		end else if (duty16) begin
			mux_sel = 3'(lcdcc_pkg::LCDCC_MUX16);
		end else if (icon_line) begin
			mux_sel = 3'(lcdcc_pkg::LCDCC_MUX33);
		end else begin
			mux_sel = 3'(lcdcc_pkg::LCDCC_MUX32);
		end
	end
	// divider off: external network sets levels, flag reads low
	assign bias_fifth = divider_on & (bias5 | duty16);
	// ----------------------------------------
	// scan mapping
	// ----------------------------------------
	always_comb begin
		logic [4:0] com_m;
		com_m = row_rev ? (`LCDCC_ROW_LAST - scan_com) : scan_com;
		scan_row = com_m + scroll;
		scan_seg_col = col_rev ? (`LCDCC_COL_LAST - scan_col)
			: scan_col;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_byte <= 8'h00;
		end else if (!display_on) begin
			scan_byte <= 8'h00;
		end else if (icon_only && scan_page != `LCDCC_PAGE_ICON) begin
			scan_byte <= 8'h00;
		end else if (int'(scan_page) < PAGES
			&& int'(scan_seg_col) < COLS) begin
			scan_byte <= ram[int'(scan_page) * COLS + int'(scan_seg_col)];
		end else begin
			scan_byte <= 8'h00;
		end
	end
	lcdcc_frame_div #(
		.W(10)
	) u_div (
		.clk(clk),
		.rst_n(rst_n),
		.osc_tick(osc_tick),
		.run(osc_enable),
		.clk_normal(clk_normal),
		.frame_tick(frame_tick)
	);
endmodule : lcdcc_core

// ### bench/lcdcc_checker.sv
`timescale 1ns/1ps
module lcdcc_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe,
	input wire logic data_command_select,
	input wire logic rw,
	input wire logic [7:0] d_in,
	input wire logic [7:0] d_out,
	input wire logic d_oe,
	input wire logic display_on,
	input wire logic bias_on,
	input wire logic [3:0] static_icon,
	input wire logic osc_enable,
	input wire logic contrast_ctrl_on,
	input wire logic [3:0] contrast,
	input wire logic [2:0] page,
	input wire logic [6:0] column
);
	logic [7:0] d_q;
	logic clr_any;
	logic clr_ram;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_cmd;
		$fell(strobe) && !data_command_select && !rw;
	endsequence
	sequence s_wr;
		$fell(strobe) && data_command_select && !rw;
	endsequence
	// ----
	// pending clear, taken by the next write
	// ----
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d_q <= 8'h00;
			clr_any <= 1'b0;
			clr_ram <= 1'b0;
		end else begin
			d_q <= d_in;
			if ($fell(strobe) && !rw) begin
				clr_any <= !data_command_select && d_in[7:1] == 7'h1b;
				clr_ram <= !data_command_select && d_in == 8'h36;
			end
		end
	end
	chk_bias_track: assert property (s_cmd ##0 d_in[7:1] == 7'h14
		|=> bias_on == d_q[0])
		else $error("bias differs from display command");
	chk_disp_on: assert property (s_cmd ##0 d_in == 8'h29 |=> display_on)
		else $error("display did not turn on");
	chk_off_keeps: assert property (s_cmd ##0 d_in[7:1] == 7'h14
		|=> $stable(osc_enable) && $stable(static_icon))
		else $error("display command disturbed icons or oscillator");
	chk_page_set: assert property (s_cmd ##0 d_in[7:3] == 5'h00 |=>
		page == (d_q[2:0] > 3'h4 ? $past(page) : d_q[2:0]))
		else $error("page pointer wrong");
	chk_col_step: assert property (s_wr ##0 !clr_any |=>
		column == ($past(column) == 7'h77 ? 7'h00 : $past(column) + 7'h01))
		else $error("column did not advance");
	chk_clr_hold: assert property (s_wr ##0 clr_ram |=> $stable(column))
		else $error("dummy write moved column");
	chk_step_wrap: assert property (s_cmd ##0 d_in[7:1] == 7'h38 |=>
		contrast == $past(contrast) + (!$past(contrast_ctrl_on) ? 4'h0 :
		d_q[0] ? 4'h1 : 4'hf))
		else $error("contrast step wrong");
	chk_read_val: assert property ($fell(strobe) && !data_command_select
		&& rw && d_in[7:4] == 4'h1 |-> ##2 d_oe && d_out[3:0] == contrast)
		else $error("contrast read wrong");
endmodule : lcdcc_checker

// ### bench/lcdcc_host.sv
`timescale 1ns/1ps
module lcdcc_host (
	input wire logic clk,
	input wire logic [7:0] d_out,
	output logic strobe,
	output logic data_command_select,
	output logic rw,
	output logic [7:0] d_in
);
	initial begin
		strobe = 1'b1;
		data_command_select = 1'b0;
		rw = 1'b0;
		d_in = 8'h00;
	end
	// one byte per strobe, held until strobe rises again
	task automatic xfer(input logic dc, input logic r, input logic [7:0] b,
		output logic [7:0] q);
		@(posedge clk);
		data_command_select <= dc;
		rw <= r;
		d_in <= b;
		@(posedge clk);
		strobe <= 1'b0;
		repeat (2) @(posedge clk);
		#1 q = d_out;
		@(posedge clk);
		strobe <= 1'b1;
		// after the strobe, drive the complement of the byte so no stale byte is left showing
		d_in <= ~b;
	endtask : xfer
endmodule : lcdcc_host

// ### bench/lcdcc_command_controller_tb.sv
`timescale 1ns/1ps
module lcdcc_command_controller_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic osc_tick = 1'b0;
	logic osc_run = 1'b0;
	logic [2:0] scan_page = 3'h0;
	logic [6:0] scan_col = 7'h00;
	logic [4:0] scan_com = 5'h00;
	logic strobe, data_command_select, rw, display_on, bias_on, osc_enable;
	logic doubler_sel, regulator_on, temp_comp_on, divider_on, icon_only;
	logic dummy_scan, frame_tick, drivers_active, osc_external, clk_normal;
	logic dcdc_on, contrast_ctrl_on, bias_fifth, idd_reduce;
	logic [7:0] d_in, d_out, scan_byte, r;
	logic [3:0] static_icon, contrast;
	logic [2:0] mux_sel, page;
	logic [6:0] column, scan_seg_col;
	logic [4:0] scan_row;
	logic [1:0] icon_contrast, temp_coef;
	int failures = 0;
	int n_tests = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) osc_tick <= osc_run & ~osc_tick;
	lcdcc_host i_host (.clk(clk), .d_out(d_out), .strobe(strobe),
		.data_command_select(data_command_select), .rw(rw), .d_in(d_in));
	lcdcc_core i_dut (.clk(clk), .rst_n(rst_n), .strobe(strobe),
		.data_command_select(data_command_select), .rw(rw), .d_in(d_in),
		.d_out(d_out), .d_oe(), .osc_tick(osc_tick), .scan_page(scan_page),
		.scan_col(scan_col), .scan_com(scan_com), .scan_byte(scan_byte),
		.scan_row(scan_row), .scan_seg_col(scan_seg_col),
		.display_on(display_on), .drivers_active(drivers_active),
		.bias_on(bias_on), .static_icon(static_icon),
		.icon_contrast(icon_contrast), .osc_enable(osc_enable),
		.osc_external(osc_external), .clk_normal(clk_normal),
		.dcdc_on(dcdc_on), .doubler_sel(doubler_sel),
		.regulator_on(regulator_on), .contrast_ctrl_on(contrast_ctrl_on),
		.temp_comp_on(temp_comp_on), .temp_coef(temp_coef),
		.divider_on(divider_on), .bias_fifth(bias_fifth),
		.contrast(contrast), .mux_sel(mux_sel), .icon_only(icon_only),
		.dummy_scan(dummy_scan), .idd_reduce(idd_reduce), .page(page),
		.column(column), .frame_tick(frame_tick));
	task automatic ck(string n, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : ck
	task automatic cmd(logic [7:0] b);
		i_host.xfer(1'b0, 1'b0, b, r);
	endtask : cmd
	task automatic wr(logic [7:0] b);
		i_host.xfer(1'b1, 1'b0, b, r);
	endtask : wr
	task automatic pos(logic [2:0] p, logic [6:0] c, logic [4:0] k);
		@(posedge clk);
		scan_page <= p;
		scan_col <= c;
		scan_com <= k;
		repeat (3) @(posedge clk);
		#1;
	endtask : pos
	task automatic frame(logic [15:0] e);
		int n;
		int c;
		n = 0;
		c = 0;
		while (frame_tick !== 1'b1 && c < 4000) begin
			@(posedge clk);
			#1 c++;
		end
		do begin
			@(posedge clk);
			#1 n += osc_tick;
			c++;
		end while (frame_tick !== 1'b1 && c < 8000);
		ck("frame", e, 16'(n));
	endtask : frame
	task automatic t_state;
		ck("ctr", 16'h0, 16'(contrast));
		ck("icc", 16'h2, 16'(icon_contrast));
		for (int p = 0; p < 6; p++) begin
			cmd(8'(p));
			ck("page", 16'(p > 4 ? 4 : p), 16'(page));
		end
		cmd(8'h7f);
		for (int a = 0; a < 4; a++) cmd(8'h61 | 8'(a << 1));
		cmd(8'h62);
		cmd(8'h29);
		ck("bias", 16'h1, 16'(bias_on));
		ck("drv", 16'h1, 16'(drivers_active));
		cmd(8'h28);
		ck("bias", 16'h0, 16'(bias_on));
		ck("drv", 16'h0, 16'(drivers_active));
		ck("icon", 16'hd, 16'(static_icon));
		ck("osc", 16'h1, 16'(osc_enable));
		cmd(8'hf6);
		wr(8'h11);
		wr(8'h22);
		ck("col", 16'h0, 16'(column));
		cmd(8'h85);
		cmd(8'h35);
		cmd(8'h89);
		cmd(8'h34);
		ck("col", 16'h5, 16'(column));
		$display("state test done");
	endtask : t_state
	task automatic t_ram;
		cmd(8'h01);
		cmd(8'h83);
		wr(8'ha5);
		pos(3'h1, 7'h03, 5'h00);
		ck("scan", 16'h0, 16'(scan_byte));
		cmd(8'h29);
		pos(3'h1, 7'h03, 5'h00);
		ck("scan", 16'ha5, 16'(scan_byte));
		cmd(8'h3e);
		pos(3'h1, 7'h03, 5'h00);
		ck("icon", 16'h0, 16'(scan_byte));
		cmd(8'h3d);
		ck("mux", 16'h2, 16'(mux_sel));
		ck("iconly", 16'h0, 16'(icon_only));
		cmd(8'h36);
		wr(8'hff);
		ck("col", 16'h4, 16'(column));
		pos(3'h1, 7'h03, 5'h00);
		ck("scan", 16'h0, 16'(scan_byte));
		pos(3'h4, 7'h76, 5'h00);
		ck("scan", 16'h11, 16'(scan_byte));
		cmd(8'h04);
		cmd(8'h83);
		wr(8'h5a);
		cmd(8'h37);
		wr(8'h00);
		pos(3'h4, 7'h03, 5'h00);
		ck("scan", 16'h0, 16'(scan_byte));
		$display("ram test done");
	endtask : t_ram
	task automatic t_map;
		cmd(8'h45);
		pos(3'h0, 7'h00, 5'h1e);
		ck("row", 16'h3, 16'(scan_row));
		cmd(8'h40);
		cmd(8'h25);
		cmd(8'h23);
		pos(3'h0, 7'h00, 5'h02);
		ck("row", 16'h1d, 16'(scan_row));
		ck("seg", 16'h77, 16'(scan_seg_col));
		cmd(8'h31);
		ck("cce", 16'h1, 16'(contrast_ctrl_on));
		cmd(8'h70);
		cmd(8'h71);
		cmd(8'h71);
		ck("ctr", 16'h1, 16'(contrast));
		cmd(8'h1a);
		i_host.xfer(1'b0, 1'b1, 8'h10, r);
		ck("rd", 16'ha, 16'(r[3:0]));
		cmd(8'h30);
		cmd(8'h71);
		ck("ctr", 16'ha, 16'(contrast));
		$display("map test done");
	endtask : t_map
	task automatic t_power;
		cmd(8'h21);
		ck("dbl", 16'h0, 16'(doubler_sel));
		cmd(8'h2b);
		ck("dcdc", 16'h1, 16'(dcdc_on));
		cmd(8'h20);
		cmd(8'h69);
		ck("dbl", 16'h1, 16'(doubler_sel));
		ck("dum", 16'h1, 16'(dummy_scan));
		cmd(8'h2d);
		ck("bf", 16'h0, 16'(bias_fifth));
		cmd(8'h2f);
		ck("reg", 16'h7, 16'({regulator_on, temp_comp_on, divider_on}));
		ck("bf", 16'h1, 16'(bias_fifth));
		cmd(8'h7b);
		cmd(8'h6e);
		cmd(8'h6b);
		cmd(8'h0d);
		ck("osx", 16'h3, 16'({osc_external, idd_reduce}));
		ck("tcic", 16'h9, 16'({temp_coef, icon_contrast}));
		ck("ctr", 16'ha, 16'(contrast));
		osc_run <= 1'b1;
		frame(16'd576);
		cmd(8'h33);
		ck("clkn", 16'h1, 16'(clk_normal));
		frame(16'd768);
		$display("power test done");
	endtask : t_power
	task automatic end_of_test;
		$display("compares %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#50000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_state();
		t_ram();
		t_map();
		t_power();
		end_of_test();
	end
endmodule : lcdcc_command_controller_tb
bind lcdcc_core lcdcc_checker i_chk (.clk(clk), .rst_n(rst_n),
	.strobe(strobe), .data_command_select(data_command_select), .rw(rw),
	.d_in(d_in), .d_out(d_out), .d_oe(d_oe), .display_on(display_on),
	.bias_on(bias_on), .static_icon(static_icon), .osc_enable(osc_enable),
	.contrast_ctrl_on(contrast_ctrl_on), .contrast(contrast), .page(page),
	.column(column));
